/* hw/gpio_ports_pkg.sv */
// Package for the four-port GPIO block: register map, masks, carriers.
// Assumes a 32-bit APB slave; one aligned word per register.
package gpio_ports_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_PORTS  = 4;
  localparam int unsigned PORT_W     = 8;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned PORT_D     = 0;
  localparam int unsigned PORT_E     = 1;
  localparam int unsigned PORT_F     = 2;
  localparam int unsigned PORT_G     = 3;
  localparam int unsigned ALT_G_W    = 5;

  // ---------------------------------------------------------------
  // Register map: port n at PORT_STRIDE * n
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PORT_STRIDE     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_LEGACY_CTL = 8'h40;
  localparam logic [1:0]        PORT_SEL_LSB    = 2'h0;
  localparam int unsigned       PORT_SEL_BIT    = 4;
  localparam int unsigned       LEGACY_BIT      = 0;

  // ---------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ---------------------------------------------------------------
  localparam logic [PORT_W-1:0] PORT_RESET  = 8'h00;
  localparam logic [PORT_W-1:0] MASK_FULL   = 8'hff;
  localparam logic [PORT_W-1:0] MASK_G      = 8'h1f;
  localparam logic [31:0]       RDATA_ZERO  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [PORT_W-1:0] out_data;
    logic [PORT_W-1:0] direction;
  } port_state_t;

  typedef struct packed {
    logic [PORT_W-1:0] level;
    logic [PORT_W-1:0] enable;
  } pin_drive_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic [31:0]       wdata;
    logic              strb0;
  } apb_req_t;

endpackage

/* hw/gpio_ports_d_to_g.sv */
// Four GPIO ports (three of eight bits, one of five) behind an APB slave.
// Assumes pins and alternate-function signals are synchronous to clk_sys_i.
`timescale 1ns/100ps
module gpio_ports_d_to_g (
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [7:0]               paddr_i,
  input  wire logic [31:0]              pwdata_i,
  input  wire logic [3:0]               pstrb_i,
  output logic                          pready_o,
  output logic [31:0]                   prdata_o,
  output logic                          pslverr_o,
  input  wire logic [3:0][7:0]          pin_in_i,
  output logic      [3:0][7:0]          pin_out_o,
  output logic      [3:0][7:0]          pin_oe_o,
  input  wire logic [4:0]               alt_g_out_i,
  input  wire logic [4:0]               alt_g_oe_i,
  output logic                          legacy_mode_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  gpio_ports_pkg::port_state_t [3:0] ports_reg;
  gpio_ports_pkg::port_state_t [3:0] ports_next;
  gpio_ports_pkg::pin_drive_t  [3:0] drive_reg;
  gpio_ports_pkg::pin_drive_t  [3:0] drive_next;
  logic                              legacy_reg;
  logic                              legacy_next;
  logic [31:0]                       rdata_reg;
  logic [31:0]                       rdata_next;
  logic                              err_reg;
  logic                              err_next;

  gpio_ports_pkg::apb_req_t req;
  logic [1:0] sel_port;
  logic [7:0] sel_ofs;
  logic       is_ctl;
  logic       is_port;
  logic       blocked;
  logic       setup;
  logic       wr_access;
  logic [7:0] wbyte;

  assign req.addr  = paddr_i;
  assign req.write = pwrite_i;
  assign req.wdata = pwdata_i;
  assign req.strb0 = pstrb_i[0];
  assign setup     = psel_i & ~penable_i;
  assign wr_access = psel_i & penable_i & req.write & ~err_reg;
  assign wbyte     = req.wdata[7:0];

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] port_mask(input logic [1:0] p);
    port_mask = (p == 2'(gpio_ports_pkg::PORT_G)) ?
                gpio_ports_pkg::MASK_G : gpio_ports_pkg::MASK_FULL;
  endfunction

  always_comb begin
    sel_port = req.addr[gpio_ports_pkg::PORT_SEL_BIT +: 2];
    sel_ofs  = req.addr & 8'h0f;
    is_ctl   = (req.addr == gpio_ports_pkg::ADDR_LEGACY_CTL);
    is_port  = (req.addr[7:6] == gpio_ports_pkg::PORT_SEL_LSB) &&
               ((sel_ofs == gpio_ports_pkg::OFS_OUTPUT) ||
                (sel_ofs == gpio_ports_pkg::OFS_DIRECTION) ||
                (sel_ofs == gpio_ports_pkg::OFS_PIN_LEVEL));
    blocked  = 1'b0;
    if (legacy_reg) begin
      if (sel_port == 2'(gpio_ports_pkg::PORT_G)) begin
        blocked = 1'b1;
      end else if (sel_port == 2'(gpio_ports_pkg::PORT_F) &&
                   sel_ofs != gpio_ports_pkg::OFS_PIN_LEVEL) begin
        blocked = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data and error, captured in the setup cycle
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup) begin
      rdata_next = gpio_ports_pkg::RDATA_ZERO;
      err_next   = 1'b0;
      if (is_ctl) begin
        rdata_next[gpio_ports_pkg::LEGACY_BIT] = legacy_reg;
      end else if (!is_port || blocked) begin
        err_next = 1'b1;
      end else if (!req.write) begin
        unique case (sel_ofs)
          gpio_ports_pkg::OFS_OUTPUT:
            rdata_next[7:0] = ports_reg[sel_port].out_data;
          gpio_ports_pkg::OFS_DIRECTION:
            rdata_next[7:0] = ports_reg[sel_port].direction;
          default:
            rdata_next[7:0] = pin_in_i[sel_port] &
                              port_mask(sel_port);
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_comb begin
    ports_next  = ports_reg;
    legacy_next = legacy_reg;
    if (wr_access && req.strb0) begin
      if (is_ctl) begin
        legacy_next = req.wdata[gpio_ports_pkg::LEGACY_BIT];
      end else if (sel_ofs == gpio_ports_pkg::OFS_OUTPUT) begin
        ports_next[sel_port].out_data =
          wbyte & port_mask(sel_port);
      end else if (sel_ofs == gpio_ports_pkg::OFS_DIRECTION) begin
        ports_next[sel_port].direction =
          wbyte & port_mask(sel_port);
      end
      // Pin-level writes fall through and change nothing
    end
  end

  // ---------------------------------------------------------------
  // Pin drive, one entry per port
  // ---------------------------------------------------------------
  for (genvar p = 0; p < gpio_ports_pkg::NUM_PORTS; p++) begin : g_drive
    always_comb begin
      drive_next[p].level  = ports_reg[p].out_data;
      drive_next[p].enable = ports_reg[p].direction;
      if (legacy_reg && p == gpio_ports_pkg::PORT_F) begin
        drive_next[p].enable = gpio_ports_pkg::PORT_RESET;
      end
      if (legacy_reg && p == gpio_ports_pkg::PORT_G) begin
        drive_next[p].level  = {3'h0, alt_g_out_i};
        drive_next[p].enable = {3'h0, alt_g_oe_i};
      end
    end
    assign pin_out_o[p] = drive_reg[p].level;
    assign pin_oe_o[p]  = drive_reg[p].enable;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < gpio_ports_pkg::NUM_PORTS; p++) begin
        ports_reg[p].out_data  <= gpio_ports_pkg::PORT_RESET;
        ports_reg[p].direction <= gpio_ports_pkg::PORT_RESET;
        drive_reg[p].level     <= gpio_ports_pkg::PORT_RESET;
        drive_reg[p].enable    <= gpio_ports_pkg::PORT_RESET;
      end
      legacy_reg <= 1'b0;
      rdata_reg  <= gpio_ports_pkg::RDATA_ZERO;
      err_reg    <= 1'b0;
    end else begin
      ports_reg  <= ports_next;
      drive_reg  <= drive_next;
      legacy_reg <= legacy_next;
      rdata_reg  <= rdata_next;
      err_reg    <= err_next;
    end
  end

  assign pready_o      = 1'b1;
  assign prdata_o      = rdata_reg;
  assign pslverr_o     = psel_i & penable_i & err_reg;
  assign legacy_mode_o = legacy_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic wr_d_out;
  logic wr_e_dir;
  logic wr_g_out;
  logic rd_d_pin;
  logic wr_pin_lvl;
  logic acc_f_legacy;
  assign wr_d_out = wr_access && req.strb0 && sel_port == 2'h0 &&
                    sel_ofs == gpio_ports_pkg::OFS_OUTPUT && is_port;
  assign wr_e_dir = wr_access && req.strb0 && sel_port == 2'h1 &&
                    sel_ofs == gpio_ports_pkg::OFS_DIRECTION && is_port;
  assign wr_g_out = psel_i && penable_i && req.write && req.strb0 &&
                    sel_port == 2'h3 && is_port &&
                    sel_ofs == gpio_ports_pkg::OFS_OUTPUT;
  assign rd_d_pin = setup && !req.write && is_port && sel_port == 2'h0 &&
                    sel_ofs == gpio_ports_pkg::OFS_PIN_LEVEL;
  assign wr_pin_lvl = wr_access && req.strb0 && is_port &&
                      sel_ofs == gpio_ports_pkg::OFS_PIN_LEVEL;
  assign acc_f_legacy = psel_i && penable_i && legacy_reg && is_port &&
                        sel_port == 2'h2 &&
                        sel_ofs != gpio_ports_pkg::OFS_PIN_LEVEL;

  property p_out_write;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_d_out |=> ports_reg[0].out_data == $past(pwdata_i[7:0]);
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output data write lost");

  property p_dir_write;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_e_dir |=> ##1 pin_oe_o[1] == $past(pwdata_i[7:0], 2);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write did not reach pin enable");

  property p_pin_read;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    rd_d_pin |=> prdata_o == {24'h0, $past(pin_in_i[0])};
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("pin level read mismatch");

  property p_g_upper_zero;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    ports_reg[3].out_data[7:5] == 3'h0 && ports_reg[3].direction[7:5] == 3'h0
    && pin_oe_o[3][7:5] == 3'h0;
  endproperty
  a_g_upper_zero: assert property (p_g_upper_zero)
    else $error("unimplemented port bits set");

  property p_g_write;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_g_out && !legacy_reg && !err_reg |=>
      ports_reg[3].out_data == ($past(pwdata_i[7:0]) & 8'h1f);
  endproperty
  a_g_write: assert property (p_g_write)
    else $error("five-bit port write wrong");

  property p_legacy_f_input;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    legacy_reg [*2] |-> pin_oe_o[2] == 8'h00;
  endproperty
  a_legacy_f_input: assert property (p_legacy_f_input)
    else $error("legacy input-only port driven");

  property p_legacy_g_locked;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_g_out && legacy_reg |-> pslverr_o ##1 $stable(ports_reg[3]);
  endproperty
  a_legacy_g_locked: assert property (p_legacy_g_locked)
    else $error("legacy port reachable");

  property p_legacy_g_alt;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    legacy_reg |=> pin_out_o[3][4:0] == $past(alt_g_out_i) &&
                   pin_oe_o[3][4:0] == $past(alt_g_oe_i);
  endproperty
  a_legacy_g_alt: assert property (p_legacy_g_alt)
    else $error("alternate function not on pins");

  property p_drive_follow;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    1'b1 |=> pin_oe_o[0] == $past(ports_reg[0].direction) &&
             pin_out_o[0] == $past(ports_reg[0].out_data);
  endproperty
  a_drive_follow: assert property (p_drive_follow)
    else $error("pin drive does not follow registers");

  property p_pin_write_ignored;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    wr_pin_lvl |=> $stable(ports_reg) && $stable(legacy_reg);
  endproperty
  a_pin_write_ignored: assert property (p_pin_write_ignored)
    else $error("pin-level write changed state");

  // ---------------------------------------------------------------
  // Refused accesses and coverage
  // ---------------------------------------------------------------
  property p_legacy_f_locked;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    acc_f_legacy |-> pslverr_o ##1 $stable(ports_reg[2]);
  endproperty
  a_legacy_f_locked: assert property (p_legacy_f_locked)
    else $error("legacy input-only port registers reachable");

  property p_refused_read_zero;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    setup && blocked |=> prdata_o == gpio_ports_pkg::RDATA_ZERO && err_reg;
  endproperty
  a_refused_read_zero: assert property (p_refused_read_zero)
    else $error("refused access returned data");

  c_write_d: cover property (@(posedge clk_sys_i) wr_d_out);
  c_read_pin: cover property (@(posedge clk_sys_i) rd_d_pin);
  c_legacy: cover property (@(posedge clk_sys_i) $rose(legacy_reg));
  c_error: cover property (@(posedge clk_sys_i) pslverr_o);
  c_legacy_f_refused: cover property (@(posedge clk_sys_i) acc_f_legacy);

endmodule

/* bench/gpio_pin_partner.sv */
// Outside circuitry on the four port pin groups.
// Assumes undriven pins take a level chosen by the bench, changed often.
`timescale 1ns/100ps
module gpio_pin_partner (
  input  wire logic [3:0][7:0] drive_val_i,
  input  wire logic [3:0][7:0] drive_en_i,
  input  wire logic [3:0][7:0] float_val_i,
  output logic      [3:0][7:0] pin_level_o
);
  // ------------------------------------------------------------
  // Pin resolution
  // ------------------------------------------------------------
  assign pin_level_o = (drive_en_i & drive_val_i)
                     | (~drive_en_i & float_val_i);
endmodule

/* bench/tb.sv */
// Self-checking bench for the four-port GPIO block, APB master plus model.
// Assumes zero or more wait states; pins resolved by gpio_pin_partner.
`timescale 1ns/100ps
module tb;
  logic            clk_sys_i, rst_b_i, psel, penable, pwrite;
  logic            pready, pslverr, legacy, er;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [3:0]      pstrb;
  logic [3:0][7:0] pin_in, pin_out, pin_oe, ext;
  logic [4:0]      alt_out, alt_oe;
  logic [7:0]      m_out[4], m_dir[4], d, r;
  logic            m_leg;
  int              miscompares, n_checks;

  gpio_ports_d_to_g u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .alt_g_out_i(alt_out), .alt_g_oe_i(alt_oe), .legacy_mode_o(legacy));
  gpio_pin_partner u_pins (.drive_val_i(pin_out), .drive_en_i(pin_oe),
    .float_val_i(ext), .pin_level_o(pin_in));

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] ad(int p, logic [7:0] o);
    return gpio_ports_pkg::PORT_STRIDE * 8'(p) + o;
  endfunction

  function automatic logic [7:0] msk(int p);
    return p == 3 ? gpio_ports_pkg::MASK_G : gpio_ports_pkg::MASK_FULL;
  endfunction

  // Expected pin level from the model state
  function automatic logic [7:0] lvl(int p);
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      if (m_leg && p == 3 && i < 5) e[i] = alt_oe[i] ? alt_out[i] : ext[p][i];
      else if (m_leg && p == 2) e[i] = ext[p][i];
      else e[i] = m_dir[p][i] ? m_out[p][i] : ext[p][i];
    end
    return e;
  endfunction

  task automatic acc(logic [7:0] a, logic w, logic [31:0] wd, logic x_er,
                     logic [31:0] x_rd);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", {31'h0, x_er}, {31'h0, er});
    if (!w) chk("prdata", x_rd, rd);
  endtask

  task automatic pins(int p);
    @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    #1;
    chk("pin_oe", {24'h0, m_dir[p]}, {24'h0, pin_oe[p]});
    chk("pin_out", {24'h0, m_out[p] & m_dir[p]},
        {24'h0, pin_out[p] & m_dir[p]});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pstrb, ext, alt_out, alt_oe} = {4'hf, 42'h0};
    rst_b_i = 1'b0;
    m_leg = 1'b0;
    for (int p = 0; p < 4; p++) {m_out[p], m_dir[p]} = 16'h0;
    void'($urandom(32'hafbec038));
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      acc(ad(p, 8'h00), 1'b0, 0, 1'b0, 0);
      acc(ad(p, 8'h04), 1'b0, 0, 1'b0, 0);
    end
    for (int k = 0; k < 8; k++) begin
      ext <= 32'($urandom());
      for (int p = 0; p < 4; p++) begin
        d = 8'($urandom());
        r = 8'($urandom());
        m_out[p] = d & msk(p);
        m_dir[p] = r & msk(p);
        acc(ad(p, 8'h00), 1'b1, {24'h0, d}, 1'b0, 0);
        acc(ad(p, 8'h04), 1'b1, {24'h0, r}, 1'b0, 0);
        acc(ad(p, 8'h08), 1'b1, 32'hff, 1'b0, 0);
        acc(ad(p, 8'h00), 1'b0, 0, 1'b0, {24'h0, m_out[p]});
        acc(ad(p, 8'h04), 1'b0, 0, 1'b0, {24'h0, m_dir[p]});
        acc(ad(p, 8'h08), 1'b0, 0, 1'b0, {24'h0, lvl(p) & msk(p)});
        pins(p);
      end
    end
    pstrb <= 4'he;
    acc(ad(0, 8'h00), 1'b1, 32'h0000_005a, 1'b0, 0);
    pstrb <= 4'hf;
    acc(ad(0, 8'h00), 1'b0, 0, 1'b0, {24'h0, m_out[0]});
    acc(8'h0c, 1'b1, 32'h1, 1'b1, 0);
    acc(8'h0c, 1'b0, 0, 1'b1, 0);
    acc(gpio_ports_pkg::ADDR_LEGACY_CTL, 1'b1, 32'h1, 1'b0, 0);
    m_leg = 1'b1;
    acc(gpio_ports_pkg::ADDR_LEGACY_CTL, 1'b0, 0, 1'b0, 32'h1);
    chk("legacy_mode", 32'h1, {31'h0, legacy});
    for (int o = 0; o < 8; o += 4) begin
      acc(ad(2, 8'(o)), 1'b1, 32'hff, 1'b1, 0);
      acc(ad(2, 8'(o)), 1'b0, 0, 1'b1, 0);
    end
    for (int o = 0; o < 12; o += 4) begin
      acc(ad(3, 8'(o)), 1'b1, 32'h1f, 1'b1, 0);
      acc(ad(3, 8'(o)), 1'b0, 0, 1'b1, 0);
    end
    acc(ad(2, 8'h08), 1'b0, 0, 1'b0, {24'h0, lvl(2)});
    chk("pin_oe_f", 32'h0, {24'h0, pin_oe[2]});
    for (int k = 0; k < 6; k++) begin
      alt_out <= 5'($urandom());
      alt_oe <= 5'($urandom());
      repeat (3) @(posedge clk_sys_i);
      chk("alt_oe", {27'h0, alt_oe}, {27'h0, pin_oe[3][4:0]});
      chk("alt_out", {27'h0, alt_oe & alt_out},
          {27'h0, alt_oe & pin_out[3][4:0]});
    end
    acc(gpio_ports_pkg::ADDR_LEGACY_CTL, 1'b1, 32'h0, 1'b0, 0);
    m_leg = 1'b0;
    acc(ad(2, 8'h00), 1'b0, 0, 1'b0, {24'h0, m_out[2]});
    chk("legacy_mode", 32'h0, {31'h0, legacy});
    acc(ad(3, 8'h04), 1'b0, 0, 1'b0, {24'h0, m_dir[3]});
    tally_and_finish();
  end
endmodule
